// *** src/fixed_point_load_exec.sv ***
module fixed_point_load_exec (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic mode64_i,
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  output logic issue_ready_o,
  output logic done_o,
  output fxload_pkg::fault_t fault_o,
  output fxload_pkg::mem_req_t mem_req_o,
  input wire logic mem_ack_i,
  input wire logic mem_dsi_i,
  input wire logic [127:0] mem_rdata_i,
  input wire fxload_pkg::gpr_wr_t gpr_load_i,
  input wire logic [4:0] gpr_rd_idx_i,
  output logic [63:0] gpr_rd_data_o,
  input wire logic xer_wr_en_i,
  input wire logic [31:0] xer_wr_data_i,
  output logic [31:0] xer_o,
  output logic [3:0] cr0_o
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_PAIR = 2'b10
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and helpers
  logic [63:0] gpr [32];

  // Replace one byte of the low word, left byte first
  function automatic logic [63:0] put_byte(input logic [63:0] old, input logic [7:0] b,
                                           input logic [1:0] pos);
    logic [63:0] r;
    r = old;
    r[31 - 8 * pos -: 8] = b;
    return r;
  endfunction

  // Access size for each operation
  function automatic fxload_pkg::size_t size_of(input fxload_pkg::op_t op);
    case (op)
      fxload_pkg::OP_LHZX: size_of = fxload_pkg::SZ_HALF;
      fxload_pkg::OP_LMW: size_of = fxload_pkg::SZ_WORD;
      fxload_pkg::OP_LQ: size_of = fxload_pkg::SZ_QUAD;
      default: size_of = fxload_pkg::SZ_BYTE;
    endcase
  endfunction

  fxload_pkg::dec_t dec;
  logic [63:0] ea;

  load_decoder u_dec (
    .instr_i(instr_i),
    .mode64_i(mode64_i),
    .dec_o(dec)
  );

  ea_unit u_ea (
    .base_i(gpr[dec.ra]),
    .index_i(gpr[dec.rb]),
    .disp_i(dec.disp),
    .base_zero_i(dec.ra == fxload_pkg::ZERO_GPR),
    .use_index_i(dec.use_rb),
    .ea_o(ea)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  state_t state_reg, state_next;
  fxload_pkg::op_t op_reg, op_next;
  logic [4:0] rt_reg, rt_next, ra_reg, ra_next, rb_reg, rb_next, ptr_reg, ptr_next;
  logic rc_reg, rc_next, match_reg, match_next, ready_reg, ready_next, done_reg, done_next;
  logic [6:0] cnt_reg, cnt_next, total_reg, total_next;
  logic [63:0] lo_reg, lo_next;
  fxload_pkg::mem_req_t req_reg, req_next;
  fxload_pkg::fault_t fault_reg, fault_next;
  logic [31:0] xer_reg, xer_next;
  logic [3:0] cr0_reg, cr0_next;
  logic [63:0] rd_reg;
  fxload_pkg::gpr_wr_t wr;
  logic hit;
  logic fin;

  // Next-state computation
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    rt_next = rt_reg;
    ra_next = ra_reg;
    rb_next = rb_reg;
    rc_next = rc_reg;
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    total_next = total_reg;
    match_next = match_reg;
    lo_next = lo_reg;
    req_next = req_reg;
    xer_next = xer_reg;
    cr0_next = cr0_reg;
    fault_next = '0;
    done_next = 1'b0;
    wr = '0;
    hit = 1'b0;
    fin = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (issue_valid_i) begin
          op_next = dec.op;
          rt_next = dec.rt;
          ra_next = dec.ra;
          rb_next = dec.rb;
          rc_next = dec.rc;
          ptr_next = dec.rt;
          cnt_next = '0;
          match_next = 1'b0;
          if (dec.illegal) begin
            fault_next.illegal = 1'b1;
          end else if (dec.bad_form) begin
            fault_next.invalid_form = 1'b1;
          end else if (dec.op == fxload_pkg::OP_LMW && ea[1:0] != 2'b00) begin
            fault_next.align = 1'b1;
          end else if (dec.op == fxload_pkg::OP_LSCBX && xer_reg[6:0] == 7'h00) begin
            done_next = 1'b1;
          end else begin
            req_next.valid = 1'b1;
            req_next.size = size_of(dec.op);
            req_next.addr = ea;
            state_next = S_WAIT;
            if (dec.op == fxload_pkg::OP_LMW) begin
              total_next = fxload_pkg::NUM_GPR - {2'b00, dec.rt};
            end else if (dec.op == fxload_pkg::OP_LSCBX) begin
              total_next = xer_reg[6:0];
            end else begin
              total_next = fxload_pkg::ONE_ITEM;
            end
          end
        end else begin
          if (gpr_load_i.en) begin
            wr = gpr_load_i;
          end
          if (xer_wr_en_i) begin
            xer_next = xer_wr_data_i;
          end
        end
      end
      S_WAIT: begin
        if (mem_dsi_i) begin
          // Abort; nothing of the progress is kept for a resume
          fault_next.dsi = 1'b1;
          req_next.valid = 1'b0;
          state_next = S_IDLE;
        end else if (mem_ack_i) begin
          cnt_next = cnt_reg + fxload_pkg::ONE_ITEM;
          case (op_reg)
            fxload_pkg::OP_LHZX: begin
              wr.en = 1'b1;
              wr.idx = rt_reg;
              wr.data = {48'h0000_0000_0000, mem_rdata_i[15:0]};
              fin = 1'b1;
            end
            fxload_pkg::OP_LQ: begin
              wr.en = 1'b1;
              wr.idx = rt_reg;
              wr.data = mem_rdata_i[127:64];
              lo_next = mem_rdata_i[63:0];
              req_next.valid = 1'b0;
              state_next = S_PAIR;
            end
            fxload_pkg::OP_LMW: begin
              // Nonzero base inside the range keeps its value
              wr.en = !(ra_reg != fxload_pkg::ZERO_GPR && ptr_reg == ra_reg);
              wr.idx = ptr_reg;
              wr.data = {32'h0000_0000, mem_rdata_i[31:0]};
              if (ptr_reg == fxload_pkg::LAST_GPR) begin
                fin = 1'b1;
              end else begin
                ptr_next = ptr_reg + 5'h01;
                req_next.addr = req_reg.addr + fxload_pkg::WORD_STEP;
              end
            end
            fxload_pkg::OP_LSCBX: begin
              hit = mem_rdata_i[7:0] == xer_reg[fxload_pkg::CMP_LSB +: 8];
              match_next = hit;
              // Base and index inside the range are left alone when the base field is nonzero
              wr.en = !(ra_reg != fxload_pkg::ZERO_GPR && (ptr_reg == ra_reg || ptr_reg == rb_reg));
              wr.idx = ptr_reg;
              wr.data = put_byte(gpr[ptr_reg], mem_rdata_i[7:0], cnt_reg[1:0]);
              if (hit || cnt_next == total_reg) begin
                fin = 1'b1;
                xer_next[6:0] = cnt_next;
                if (rc_reg) begin
                  cr0_next = {2'b00, hit, xer_reg[fxload_pkg::SO_BIT]};
                end
              end else begin
                if (cnt_reg[1:0] == 2'b11) begin
                  ptr_next = ptr_reg + 5'h01;
                end
                req_next.addr = req_reg.addr + fxload_pkg::BYTE_STEP;
              end
            end
            default: begin
              fin = 1'b1;
            end
          endcase
          if (fin) begin
            req_next.valid = 1'b0;
            done_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_PAIR: begin
        wr.en = 1'b1;
        wr.idx = rt_reg + 5'h01;
        wr.data = lo_reg;
        done_next = 1'b1;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
        req_next.valid = 1'b0;
      end
    endcase
    ready_next = state_next == S_IDLE;
  end

  // State registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      op_reg <= fxload_pkg::OP_NONE;
      rt_reg <= '0;
      ra_reg <= '0;
      rb_reg <= '0;
      rc_reg <= 1'b0;
      ptr_reg <= '0;
      cnt_reg <= '0;
      total_reg <= '0;
      match_reg <= 1'b0;
      lo_reg <= '0;
      req_reg <= '0;
      fault_reg <= '0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
      xer_reg <= fxload_pkg::XER_RST;
      cr0_reg <= fxload_pkg::CR0_RST;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      rt_reg <= rt_next;
      ra_reg <= ra_next;
      rb_reg <= rb_next;
      rc_reg <= rc_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      total_reg <= total_next;
      match_reg <= match_next;
      lo_reg <= lo_next;
      req_reg <= req_next;
      fault_reg <= fault_next;
      done_reg <= done_next;
      ready_reg <= ready_next;
      xer_reg <= xer_next;
      cr0_reg <= cr0_next;
    end
  end

  // Register file write and registered read
  always_ff @(posedge sys_clk_i) begin
    if (wr.en) begin
      gpr[wr.idx] <= wr.data;
    end
    rd_reg <= gpr[gpr_rd_idx_i];
  end

  assign issue_ready_o = ready_reg;
  assign done_o = done_reg;
  assign fault_o = fault_reg;
  assign mem_req_o = req_reg;
  assign gpr_rd_data_o = rd_reg;
  assign xer_o = xer_reg;
  assign cr0_o = cr0_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic issue_go;
  assign issue_go = issue_valid_i && state_reg == S_IDLE;

  property p_half_zero;
    wr.en && state_reg == S_WAIT && op_reg == fxload_pkg::OP_LHZX |-> wr.data[63:16] == '0;
  endproperty
  a_half_zero: assert property (p_half_zero) else $error("halfword upper bits not zero");

  property p_half_keeps_flags;
    done_o && op_reg == fxload_pkg::OP_LHZX |-> $stable(xer_o) && $stable(cr0_o);
  endproperty
  a_half_keeps_flags: assert property (p_half_keeps_flags) else $error("halfword load changed flags");

  property p_base_skip;
    wr.en && state_reg == S_WAIT && op_reg == fxload_pkg::OP_LMW && ra_reg != 5'h00 |-> wr.idx != ra_reg;
  endproperty
  a_base_skip: assert property (p_base_skip) else $error("base register overwritten");

  property p_misalign;
    issue_go && !dec.illegal && dec.op == fxload_pkg::OP_LMW && ea[1:0] != 2'b00
      |=> fault_o.align && !mem_req_o.valid && issue_ready_o;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned multiple not refused");

  property p_odd_pair;
    issue_go && dec.op == fxload_pkg::OP_LQ && mode64_i && dec.rt[0] |=> fault_o.invalid_form;
  endproperty
  a_odd_pair: assert property (p_odd_pair) else $error("odd quad target accepted");

  property p_quad_32;
    issue_go && dec.op == fxload_pkg::OP_LQ && !mode64_i |=> fault_o.illegal && !mem_req_o.valid;
  endproperty
  a_quad_32: assert property (p_quad_32) else $error("quad load ran in 32-bit mode");

  property p_pair_second;
    state_reg == S_WAIT && op_reg == fxload_pkg::OP_LQ && mem_ack_i && !mem_dsi_i
      |=> wr.en && wr.idx == rt_reg + 5'h01 ##1 done_o;
  endproperty
  a_pair_second: assert property (p_pair_second) else $error("second quad half missing");

  property p_stop_on_match;
    state_reg == S_WAIT && op_reg == fxload_pkg::OP_LSCBX && mem_ack_i && !mem_dsi_i && hit
      |=> !mem_req_o.valid ##1 (!mem_req_o.valid || $past(issue_go));
  endproperty
  a_stop_on_match: assert property (p_stop_on_match) else $error("access after match");

  property p_count_back;
    done_o && op_reg == fxload_pkg::OP_LSCBX && cnt_reg != 7'h00
      |-> xer_o[6:0] == cnt_reg && (match_reg || cnt_reg == total_reg);
  endproperty
  a_count_back: assert property (p_count_back) else $error("byte count not returned");

  property p_record;
    done_o && op_reg == fxload_pkg::OP_LSCBX && rc_reg && cnt_reg != 7'h00
      |-> cr0_o == {2'b00, match_reg, xer_o[31]};
  endproperty
  a_record: assert property (p_record) else $error("condition field wrong");

  property p_fault_abort;
    state_reg == S_WAIT && mem_dsi_i |=> fault_o.dsi && issue_ready_o && !done_o;
  endproperty
  a_fault_abort: assert property (p_fault_abort) else $error("fault did not abort");

  c_half: cover property (done_o && op_reg == fxload_pkg::OP_LHZX);
  c_multi: cover property (done_o && op_reg == fxload_pkg::OP_LMW && total_reg > 7'h02);
  c_quad: cover property (done_o && op_reg == fxload_pkg::OP_LQ);
  c_match: cover property (done_o && op_reg == fxload_pkg::OP_LSCBX && match_reg);
  c_fault: cover property (fault_o.dsi);
endmodule // fixed_point_load_exec

// *** src/fxload_pkg.sv ***
package fxload_pkg;
  localparam logic [5:0] OPC_EXT = 6'h1f;
  localparam logic [5:0] OPC_LMW = 6'h2e;
  localparam logic [5:0] OPC_LQ = 6'h38;
  localparam logic [9:0] XO_LHZX = 10'h117;
  localparam logic [9:0] XO_LSCBX = 10'h115;
  localparam logic [3:0] LQ_LOW_ZERO = 4'h0;
  localparam int CMP_LSB = 8;
  localparam int SO_BIT = 31;
  localparam logic [4:0] LAST_GPR = 5'h1f;
  localparam logic [4:0] ZERO_GPR = 5'h00;
  localparam logic [6:0] NUM_GPR = 7'h20;
  localparam logic [6:0] ONE_ITEM = 7'h01;
  localparam logic [63:0] WORD_STEP = 64'h0000_0000_0000_0004;
  localparam logic [63:0] BYTE_STEP = 64'h0000_0000_0000_0001;
  localparam logic [31:0] XER_RST = 32'h0000_0000;
  localparam logic [3:0] CR0_RST = 4'h0;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LHZX = 3'b001,
    OP_LMW = 3'b010,
    OP_LQ = 3'b011,
    OP_LSCBX = 3'b100
  } op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10,
    SZ_QUAD = 2'b11
  } size_t;

  typedef struct packed {
    op_t op;
    logic [4:0] rt;
    logic [4:0] ra;
    logic [4:0] rb;
    logic rc;
    logic use_rb;
    logic illegal;
    logic bad_form;
    logic [63:0] disp;
  } dec_t;

  typedef struct packed {
    logic valid;
    size_t size;
    logic [63:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic en;
    logic [4:0] idx;
    logic [63:0] data;
  } gpr_wr_t;

  typedef struct packed {
    logic illegal;
    logic invalid_form;
    logic align;
    logic dsi;
  } fault_t;
endpackage

// *** src/load_decoder.sv ***
module load_decoder (
  input wire logic [31:0] instr_i,
  input wire logic mode64_i,
  output fxload_pkg::dec_t dec_o
);
  logic [5:0] opc;
  logic [9:0] xo;

  assign opc = instr_i[31:26];
  assign xo = instr_i[10:1];

  // Field extraction and opcode match
  always_comb begin
    dec_o = '0;
    dec_o.rt = instr_i[25:21];
    dec_o.ra = instr_i[20:16];
    dec_o.rb = instr_i[15:11];
    dec_o.rc = instr_i[0];
    dec_o.op = fxload_pkg::OP_NONE;
    if (opc == fxload_pkg::OPC_EXT && xo == fxload_pkg::XO_LHZX) begin
      dec_o.op = fxload_pkg::OP_LHZX;
      dec_o.use_rb = 1'b1;
    end else if (opc == fxload_pkg::OPC_EXT && xo == fxload_pkg::XO_LSCBX) begin
      dec_o.op = fxload_pkg::OP_LSCBX;
      dec_o.use_rb = 1'b1;
    end else if (opc == fxload_pkg::OPC_LMW) begin
      dec_o.op = fxload_pkg::OP_LMW;
      dec_o.disp = {{48{instr_i[15]}}, instr_i[15:0]};
    end else if (opc == fxload_pkg::OPC_LQ && instr_i[3:0] == fxload_pkg::LQ_LOW_ZERO) begin
      dec_o.op = fxload_pkg::OP_LQ;
      dec_o.disp = {{48{instr_i[15]}}, instr_i[15:4], 4'h0};
      dec_o.bad_form = instr_i[21];
      dec_o.illegal = !mode64_i;
    end
    // Anything else is not handled here
    if (dec_o.op == fxload_pkg::OP_NONE) begin
      dec_o.illegal = 1'b1;
    end
  end
endmodule // load_decoder

// *** src/ea_unit.sv ***
module ea_unit (
  input wire logic [63:0] base_i,
  input wire logic [63:0] index_i,
  input wire logic [63:0] disp_i,
  input wire logic base_zero_i,
  input wire logic use_index_i,
  output logic [63:0] ea_o
);
  logic [63:0] offset;

  // Base field zero means no base term
  always_comb begin
    offset = use_index_i ? index_i : disp_i;
    ea_o = base_zero_i ? offset : base_i + offset;
  end
endmodule // ea_unit

// *** dv/mem_model.sv ***
module mem_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire fxload_pkg::mem_req_t mem_req_i,
  input wire logic [3:0] delay_i,
  input wire logic [15:0] dsi_at_i,
  output logic mem_ack_o,
  output logic mem_dsi_o,
  output logic [127:0] mem_rdata_o,
  output logic [15:0] n_acc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  logic [127:0] line;

  // Byte pattern derived from the address
  function automatic logic [7:0] mb(logic [63:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  // Big-endian line, narrow sizes right-justified
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      line[127 - 8 * k -: 8] = mb(mem_req_i.addr + 64'(k));
    end
    if (mem_req_i.size != fxload_pkg::SZ_QUAD) begin
      line = line >> (128 - (8 << mem_req_i.size));
    end
  end

  // Inverse pattern outside answers so stale data never passes
  assign mem_rdata_o = mem_ack_o ? line : ~line;

  // Answer after delay_i cycles; ignore the request in the cycle of an answer
  always @(posedge sys_clk_i) begin
    mem_ack_o <= 1'b0;
    mem_dsi_o <= 1'b0;
    if (rst_i) begin
      wait_reg <= 4'h0;
      n_acc_o <= 16'h0000;
    end else if (!mem_req_i.valid || mem_ack_o || mem_dsi_o) begin
      wait_reg <= 4'h0;
    end else if (wait_reg == delay_i) begin
      if (n_acc_o == dsi_at_i) begin
        mem_dsi_o <= 1'b1;
      end else begin
        mem_ack_o <= 1'b1;
      end
      n_acc_o <= n_acc_o + 16'h0001;
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // mem_model

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic m64 = 1'b1;
  logic iv = 1'b0;
  logic xwe = 1'b0;
  logic [31:0] instr = 32'h0000_0000;
  logic [31:0] xwd = 32'h0000_0000;
  logic [4:0] ri = 5'h00;
  logic [3:0] dly = 4'h0;
  logic [15:0] dsi_at = 16'hffff;
  logic [15:0] seed = 16'h42c5;
  logic [3:0] cr_exp = 4'h0;
  fxload_pkg::gpr_wr_t gl = '0;
  fxload_pkg::mem_req_t req;
  fxload_pkg::fault_t flt;
  logic rdy, dn, ack, dsi;
  logic [127:0] rdat;
  logic [63:0] rd;
  logic [31:0] fixed_exception_reg;
  logic [3:0] cr0;
  logic [15:0] nacc;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // Clock
  always #5 clk = ~clk;

  fixed_point_load_exec dut (
    .sys_clk_i(clk), .rst_i(rst), .mode64_i(m64), .issue_valid_i(iv), .instr_i(instr),
    .issue_ready_o(rdy), .done_o(dn), .fault_o(flt), .mem_req_o(req), .mem_ack_i(ack),
    .mem_dsi_i(dsi), .mem_rdata_i(rdat), .gpr_load_i(gl), .gpr_rd_idx_i(ri), .gpr_rd_data_o(rd),
    .xer_wr_en_i(xwe), .xer_wr_data_i(xwd), .xer_o(fixed_exception_reg), .cr0_o(cr0)
  );

  mem_model mem (
    .sys_clk_i(clk), .rst_i(rst), .mem_req_i(req), .delay_i(dly), .dsi_at_i(dsi_at),
    .mem_ack_o(ack), .mem_dsi_o(dsi), .mem_rdata_o(rdat), .n_acc_o(nacc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [7:0] mb(logic [63:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  function automatic logic [63:0] mw(logic [63:0] a, int n);
    logic [63:0] v = '0;
    for (int k = 0; k < n; k++) v = {v[55:0], mb(a + 64'(k))};
    return v;
  endfunction

  function automatic logic [31:0] xf(logic [4:0] t, logic [4:0] a, logic [4:0] b, logic [9:0] xo, logic rc);
    return {fxload_pkg::OPC_EXT, t, a, b, xo, rc};
  endfunction

  function automatic logic [31:0] df(logic [5:0] op, logic [4:0] t, logic [4:0] a, logic [15:0] d);
    return {op, t, a, d};
  endfunction

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Driver and check tasks
  task chk(string nm, logic [63:0] e, logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task wg(logic [4:0] i, logic [63:0] d);
    @(posedge clk) gl <= '{1'b1, i, d};
    @(posedge clk) gl.en <= 1'b0;
  endtask

  task rg(logic [4:0] i, output logic [63:0] v);
    @(posedge clk) ri <= i;
    repeat (2) @(posedge clk);
    #1 v = rd;
  endtask

  task wx(logic [31:0] v);
    @(posedge clk) begin
      xwe <= 1'b1;
      xwd <= v;
    end
    @(posedge clk) xwe <= 1'b0;
  endtask

  task ex(logic [31:0] i, logic [3:0] ef);
    int k;
    @(posedge clk) begin
      iv <= 1'b1;
      instr <= i;
    end
    @(posedge clk) iv <= 1'b0;
    // Faults and zero-count completions pulse right after the issue edge
    #1;
    for (k = 0; k < 300; k++) begin
      if (dn === 1'b1 || flt !== 4'h0) break;
      chk("busy", 64'h0, rdy);
      @(posedge clk);
      #1;
    end
    chk("fault", ef, flt);
    chk("done", ef == 4'h0, dn);
    chk("ready", 64'h1, rdy);
  endtask

  task lmchk(logic [4:0] t, logic [63:0] ea, logic [4:0] skip, logic [63:0] keep);
    logic [63:0] v;
    for (int r = t; r < 32; r++) begin
      rg(5'(r), v);
      chk("lmw gpr", 5'(r) == skip ? keep : mw(ea + 64'(4 * (r - t)), 4), v);
    end
  endtask

  // String compare load from 0x310 with base 2 and index 3
  task lsx(logic [4:0] t, logic [6:0] n, logic [7:0] cmp, logic rc, logic so);
    logic [63:0] v;
    logic [15:0] n0;
    logic [6:0] m;
    logic [4:0] r;
    m = n;
    for (int k = n - 1; k >= 0; k--) if (mb(64'h310 + 64'(k)) == cmp) m = 7'(k + 1);
    if (rc && n != 7'h00) cr_exp = {2'b00, mb(64'h30f + 64'(m)) == cmp, so};
    wx({so, 15'h0000, cmp, 1'b0, n});
    n0 = nacc;
    ex(xf(t, 5'h02, 5'h03, fxload_pkg::XO_LSCBX, rc), 4'h0);
    chk("lscbx accesses", 64'(m), 64'(nacc - n0));
    chk("lscbx xer", {so, 15'h0000, cmp, 1'b0, m}, fixed_exception_reg);
    chk("lscbx cr0", cr_exp, cr0);
    for (int k = 0; k < m; k++) begin
      r = t + 5'(k / 4);
      rg(r, v);
      if (r != 5'h02 && r != 5'h03) chk("lscbx byte", mb(64'h310 + 64'(k)), v[31 - 8 * (k % 4) -: 8]);
    end
    rg(5'h02, v);
    chk("base kept", 64'h300, v);
    rg(5'h03, v);
    chk("index kept", 64'h10, v);
  endtask

  task test_done();
    $display("Checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [63:0] a, b, v;
    logic [15:0] n0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      a = {48'h0, seed};
      seed = lfsr(seed);
      b = {56'h0, seed[7:0]};
      wg(5'h05, a);
      wg(5'h04, b);
      wg(5'h06, '1);
      wx({seed, ~seed});
      ex(xf(5'h06, i[0] ? 5'h05 : 5'h00, 5'h04, fxload_pkg::XO_LHZX, 1'b0), 4'h0);
      rg(5'h06, v);
      chk("lhzx gpr", mw((i[0] ? a : 64'h0) + b, 2), v);
      chk("lhzx xer", {seed, ~seed}, fixed_exception_reg);
      chk("lhzx cr0", 64'h0, cr0);
    end
    $display("test lhzx finished");
    dly = 4'h2;
    seed = lfsr(seed);
    a = {48'h0, seed[15:2], 2'b00};
    wg(5'h01, a);
    n0 = nacc;
    ex(df(fxload_pkg::OPC_LMW, 5'h1d, 5'h01, 16'hfff8), 4'h0);
    chk("lmw accesses", 64'h3, 64'(nacc - n0));
    lmchk(5'h1d, a - 64'h8, 5'h00, 64'h0);
    ex(df(fxload_pkg::OPC_LMW, 5'h1e, 5'h00, 16'h0100), 4'h0);
    lmchk(5'h1e, 64'h100, 5'h00, 64'h0);
    wg(5'h1e, 64'h200);
    ex(df(fxload_pkg::OPC_LMW, 5'h1c, 5'h1e, 16'h0000), 4'h0);
    lmchk(5'h1c, 64'h200, 5'h1e, 64'h200);
    n0 = nacc;
    ex(df(fxload_pkg::OPC_LMW, 5'h1e, 5'h00, 16'h0002), 4'h2);
    chk("align accesses", 64'h0, 64'(nacc - n0));
    dsi_at = nacc + 16'h0001;
    ex(df(fxload_pkg::OPC_LMW, 5'h1d, 5'h01, 16'h0000), 4'h1);
    dsi_at = 16'hffff;
    n0 = nacc;
    ex(df(fxload_pkg::OPC_LMW, 5'h1d, 5'h01, 16'h0000), 4'h0);
    chk("rerun accesses", 64'h3, 64'(nacc - n0));
    lmchk(5'h1d, a, 5'h00, 64'h0);
    $display("test lmw finished");
    dly = 4'h0;
    wg(5'h07, 64'h1000);
    ex(df(fxload_pkg::OPC_LQ, 5'h04, 5'h07, 16'hfff0), 4'h0);
    rg(5'h04, v);
    chk("lq first", mw(64'h0ff0, 8), v);
    rg(5'h05, v);
    chk("lq second", mw(64'h0ff8, 8), v);
    ex(df(fxload_pkg::OPC_LQ, 5'h06, 5'h00, 16'h0010), 4'h0);
    rg(5'h07, v);
    chk("lq base zero", mw(64'h0018, 8), v);
    ex(df(fxload_pkg::OPC_LQ, 5'h05, 5'h00, 16'h0000), 4'h4);
    ex(df(fxload_pkg::OPC_LQ, 5'h04, 5'h00, 16'h0001), 4'h8);
    @(posedge clk) m64 <= 1'b0;
    ex(df(fxload_pkg::OPC_LQ, 5'h04, 5'h00, 16'h0000), 4'h8);
    @(posedge clk) m64 <= 1'b1;
    $display("test lq finished");
    dly = 4'h1;
    wg(5'h02, 64'h300);
    wg(5'h03, 64'h10);
    lsx(5'h1f, 7'h09, mb(64'h315), 1'b1, 1'b1);
    lsx(5'h06, 7'h05, mb(64'h330), 1'b0, 1'b0);
    lsx(5'h01, 7'h0c, mb(64'h330), 1'b1, 1'b0);
    wg(5'h08, 64'h1234);
    lsx(5'h08, 7'h00, 8'h00, 1'b1, 1'b0);
    rg(5'h08, v);
    chk("zero count gpr", 64'h1234, v);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      lsx(5'h0a, 7'(seed[4:0]) + 7'h01, mb(64'h310 + 64'(seed[12:8])), seed[15], seed[14]);
    end
    wx(32'h0000_ff07);
    dsi_at = nacc + 16'h0002;
    ex(xf(5'h06, 5'h02, 5'h03, fxload_pkg::XO_LSCBX, 1'b1), 4'h1);
    dsi_at = 16'hffff;
    chk("dsi xer", 64'h0000_ff07, fixed_exception_reg);
    lsx(5'h06, 7'h07, mb(64'h316), 1'b1, 1'b0);
    $display("test lscbx finished");
    test_done();
  end
endmodule // tb
